// ### include/ahl_defs.svh
// offsets, field positions and reset values of the axis homing block
// assumes inclusion by bare name from the design
`ifndef AHL_DEFS_SVH
`define AHL_DEFS_SVH
`define AHL_OFF_AUTOSCALE 8'hc0
`define AHL_OFF_MODE      8'hc1
`define AHL_OFF_ROUGH     8'hc2
`define AHL_OFF_FINE      8'hc3
`define AHL_OFF_SPAN      8'hc4
`define AHL_OFF_PRIOR     8'hc5
`define AHL_OFF_LAT_ACT   8'hc6
`define AHL_OFF_LAT_ENC   8'hc7
`define AHL_OFF_ENC_CFG   8'hc9
`define AHL_OFF_FULLSTEP  8'hca
`define AHL_OFF_COIL      8'hcc
`define AHL_OFF_LOAD      8'hce
`define AHL_OFF_FAULT     8'hcf
`define AHL_RST_FULLSTEP  16'h00c8
`define AHL_RST_MODE      8'h01
`define AHL_EC_A_LVL      0
`define AHL_EC_B_LVL      1
`define AHL_EC_N_LVL      2
`define AHL_EC_AB_IGN     3
`define AHL_EC_EVERY      4
`define AHL_EC_NEXT       5
`define AHL_EC_CLEAR      8
`define AHL_MODE_INV_HOME 7
`define AHL_MODE_RIGHT    6
`endif

// ### include/ahl_pkg.sv
// types of the axis homing and encoder latch block
// assumes ahl_defs.svh on the include path
package ahl_pkg;
  typedef enum logic [2:0] {
    H_IDLE, H_FIRST, H_SEEK, H_LEAVE, H_BACK, H_ZERO
  } ahl_hstate_type;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } ahl_bus_type;

  typedef struct packed {
    logic stop_left;
    logic stop_right;
    logic home;
  } ahl_sw_type;

  typedef struct packed {
    logic a;
    logic b;
    logic n;
  } ahl_enc_type;

  typedef struct packed {
    ahl_hstate_type st;
    logic           autoscale;
    logic [7:0]     mode;
    logic [31:0]    rough;
    logic [31:0]    fine;
    logic [31:0]    span;
    logic [31:0]    prior;
    logic [31:0]    lat_act;
    logic [31:0]    lat_enc;
    logic [8:0]     enc_cfg;
    logic [15:0]    fullsteps;
    logic [1:0]     coil_opt;
    logic [1:0]     faults;
    logic [31:0]    right_pos;
    logic           tgt_right;
    logic           second;
    logic           null_prev;
    logic [31:0]    rdata;
    logic           busy;
    logic           moving;
    logic           dir;
    logic [31:0]    speed;
    logic           pos_zero;
    logic           enc_clear;
    logic [1:0]     coil;
  } ahl_state_type;
endpackage : ahl_pkg

// ### rtl/ahl_axis.sv
// one axis: homing search, null-channel latching and status registers
// assumes all inputs synchronous to mclk, position counters outside
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`include "ahl_defs.svh"

////////////////////////////////////////////////////////////////////////
// Summary of operation
// - autoscale flag picks user or automatic amplitude
// - modes 1-4 search stop switches only
// - modes 5/6 seek home, reverse at stop
// - modes 7/8 seek home, ignore end switches
// - plus 128 inverts home input, modes 5-8
// - plus 64 seeks right switch, modes 1/4
// - rough speed while approaching the switch
// - fine speed while finding switching point
// - modes 2/3 report distance between switches
// - save position before zeroing it
// - null event latches actual position
// - null event latches encoder counter
// - bits 0/1 give required A/B levels
// - bit 2 null level, bit 3 ignores A/B
// - bit 4 every event, bit 5 next only
// - bit 8 also clears encoder counter
// - full steps per turn, default 200
// - zero standby current selects coil state
// - load value readable, up to 1023
// - flags: 1 stall, 2 deviation, combinable
// - flags clear on read and on search
module ahl_axis
  import ahl_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  input  wire ahl_bus_type bus_req,
  output logic [31:0]      bus_rdata,
  input  wire logic        homing_search_command,
  input  wire ahl_sw_type  sw,
  input  wire ahl_enc_type enc,
  input  wire logic [31:0] actual_pos,
  input  wire logic [31:0] encoder_count,
  input  wire logic [9:0]  load_value,
  input  wire logic        stall_event,
  input  wire logic        deviation_event,
  input  wire logic        standby_zero,
  output logic             amp_auto,
  output logic             homing_busy,
  output logic             move_active,
  output logic             move_dir_pos,
  output logic [31:0]      move_speed,
  output logic             pos_zero,
  output logic             enc_clear,
  output logic [1:0]       coil_state,
  output logic [15:0]      fullsteps_out
);

  ahl_state_type s_reg;
  ahl_state_type s_next;
  logic [5:0]    base;
  logic          home_kind;
  logic          home_eff;
  logic          sw_hit;
  logic          both_sides;
  logic          null_lvl;
  logic          null_fire;
  logic          wr_cfg;

  ////////////////////////////////////////////////////////////////////////
  // decoded search mode
  always_comb begin
    base       = s_reg.mode[5:0];
    home_kind  = (base >= 6'h05) && (base <= 6'h08);
    // only home modes honour the inversion bit
    home_eff   = sw.home ^ (home_kind && s_reg.mode[`AHL_MODE_INV_HOME]);
    sw_hit     = home_kind ? home_eff
               : (s_reg.tgt_right ? sw.stop_right : sw.stop_left);
    both_sides = (base == 6'h03) || (base == 6'h04);
  end

  ////////////////////////////////////////////////////////////////////////
  // null channel qualification
  always_comb begin
    null_lvl = (enc.n == s_reg.enc_cfg[`AHL_EC_N_LVL]) &&
               (s_reg.enc_cfg[`AHL_EC_AB_IGN] ||
                ((enc.a == s_reg.enc_cfg[`AHL_EC_A_LVL]) &&
                 (enc.b == s_reg.enc_cfg[`AHL_EC_B_LVL])));
    // edge, so a long null pulse latches once
    null_fire = null_lvl && !s_reg.null_prev &&
                (s_reg.enc_cfg[`AHL_EC_EVERY] ||
                 s_reg.enc_cfg[`AHL_EC_NEXT]);
    wr_cfg = bus_req.wr && (bus_req.addr == `AHL_OFF_ENC_CFG);
  end

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_next           = s_reg;
    s_next.pos_zero  = 1'b0;
    s_next.enc_clear = 1'b0;
    s_next.rdata     = 32'h0000_0000;
    s_next.null_prev = null_lvl;
    s_next.coil      = standby_zero ? s_reg.coil_opt : 2'h0;

    if (null_fire) begin
      s_next.lat_act = actual_pos;
      s_next.lat_enc = encoder_count;
      s_next.enc_clear = s_reg.enc_cfg[`AHL_EC_CLEAR];
      s_next.enc_cfg[`AHL_EC_NEXT] = 1'b0;
    end

    if (bus_req.rd) begin
      case (bus_req.addr)
        `AHL_OFF_AUTOSCALE: s_next.rdata = {31'h0, s_reg.autoscale};
        `AHL_OFF_MODE:      s_next.rdata = {24'h0, s_reg.mode};
        `AHL_OFF_ROUGH:     s_next.rdata = s_reg.rough;
        `AHL_OFF_FINE:      s_next.rdata = s_reg.fine;
        `AHL_OFF_SPAN:      s_next.rdata = s_reg.span;
        `AHL_OFF_PRIOR:     s_next.rdata = s_reg.prior;
        `AHL_OFF_LAT_ACT:   s_next.rdata = s_reg.lat_act;
        `AHL_OFF_LAT_ENC:   s_next.rdata = s_reg.lat_enc;
        `AHL_OFF_ENC_CFG:   s_next.rdata = {23'h0, s_reg.enc_cfg};
        `AHL_OFF_FULLSTEP:  s_next.rdata = {16'h0, s_reg.fullsteps};
        `AHL_OFF_COIL:      s_next.rdata = {30'h0, s_reg.coil_opt};
        `AHL_OFF_LOAD:      s_next.rdata = {22'h0, load_value};
        `AHL_OFF_FAULT: begin
          s_next.rdata  = {30'h0, s_reg.faults};
          s_next.faults = 2'h0;
        end
        default:            s_next.rdata = 32'h0000_0000;
      endcase
    end

    if (bus_req.wr) begin
      case (bus_req.addr)
        `AHL_OFF_AUTOSCALE: s_next.autoscale = bus_req.wdata[0];
        `AHL_OFF_MODE:      s_next.mode = bus_req.wdata[7:0];
        `AHL_OFF_ROUGH:     s_next.rough = bus_req.wdata;
        `AHL_OFF_FINE:      s_next.fine = bus_req.wdata;
        // software write beats the one-shot self clear
        `AHL_OFF_ENC_CFG:   s_next.enc_cfg = bus_req.wdata[8:0];
        `AHL_OFF_FULLSTEP:  s_next.fullsteps = bus_req.wdata[15:0];
        `AHL_OFF_COIL:      s_next.coil_opt = bus_req.wdata[1:0];
        default: ;
      endcase
    end

    case (s_reg.st)
      H_IDLE: begin
        if (homing_search_command) begin
          s_next.faults = 2'h0;
          s_next.second = 1'b0;
          if ((base >= 6'h01) && (base <= 6'h08)) begin
            s_next.busy   = 1'b1;
            s_next.moving = 1'b1;
            s_next.speed  = s_reg.rough;
            if ((base == 6'h02) || (base == 6'h03)) begin
              s_next.st  = H_FIRST;
              s_next.dir = 1'b1;
            end else begin
              s_next.st  = H_SEEK;
              s_next.dir = home_kind
                ? ((base == 6'h06) || (base == 6'h07))
                : s_reg.mode[`AHL_MODE_RIGHT];
              s_next.tgt_right = s_reg.mode[`AHL_MODE_RIGHT];
            end
          end
        end
      end
      H_FIRST: begin
        if (sw.stop_right) begin
          s_next.right_pos = actual_pos;
          s_next.st        = H_SEEK;
          s_next.dir       = 1'b0;
          s_next.tgt_right = 1'b0;
        end
      end
      H_SEEK: begin
        if (sw_hit) begin
          s_next.st    = H_LEAVE;
          s_next.dir   = !s_reg.dir;
          s_next.speed = s_reg.fine;
        end else if ((base == 6'h05) && sw.stop_left) begin
          s_next.dir = 1'b1;
        end else if ((base == 6'h06) && sw.stop_right) begin
          s_next.dir = 1'b0;
        end
      end
      H_LEAVE: begin
        if (!sw_hit) begin
          if (both_sides && !s_reg.second) begin
            s_next.st     = H_BACK;
            s_next.dir    = !s_reg.dir;
            s_next.second = 1'b1;
          end else begin
            s_next.st     = H_ZERO;
            s_next.moving = 1'b0;
          end
        end
      end
      H_BACK: begin
        if (sw_hit) begin
          s_next.st     = H_ZERO;
          s_next.moving = 1'b0;
        end
      end
      H_ZERO: begin
        // counter outside zeroes on pos_zero, so sample it now
        s_next.prior    = actual_pos;
        s_next.pos_zero = 1'b1;
        if ((base == 6'h02) || (base == 6'h03)) begin
          s_next.span = s_reg.right_pos - actual_pos;
        end
        s_next.busy = 1'b0;
        s_next.st   = H_IDLE;
      end
      default: s_next.st = H_IDLE;
    endcase

    // set beats the clear by read or command
    if (stall_event) begin
      s_next.faults[0] = 1'b1;
    end
    if (deviation_event) begin
      s_next.faults[1] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register; clk_en low freezes everything
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_reg           <= '0;
      s_reg.st        <= H_IDLE;
      s_reg.mode      <= `AHL_RST_MODE;
      s_reg.fullsteps <= `AHL_RST_FULLSTEP;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  assign bus_rdata     = s_reg.rdata;
  assign amp_auto      = s_reg.autoscale;
  assign homing_busy   = s_reg.busy;
  assign move_active   = s_reg.moving;
  assign move_dir_pos  = s_reg.dir;
  assign move_speed    = s_reg.speed;
  assign pos_zero      = s_reg.pos_zero;
  assign enc_clear     = s_reg.enc_clear;
  assign coil_state    = s_reg.coil;
  assign fullsteps_out = s_reg.fullsteps;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence null_seen;
    clk_en && null_fire;
  endsequence

  sequence latched_both;
    (s_reg.lat_act == $past(actual_pos)) &&
    (s_reg.lat_enc == $past(encoder_count));
  endsequence

  chk_null_latch_pair: assert property (
    null_seen |=> latched_both)
    else $error("null event did not latch both positions");

  chk_null_enc_clear: assert property (
    null_seen |=> (enc_clear == $past(s_reg.enc_cfg[`AHL_EC_CLEAR])))
    else $error("encoder clear pulse wrong on null event");

  chk_null_oneshot: assert property (
    null_seen ##0 (!wr_cfg && s_reg.enc_cfg[`AHL_EC_NEXT])
      |=> !s_reg.enc_cfg[`AHL_EC_NEXT])
    else $error("one-shot null arm not cleared");

  chk_zero_saves_pos: assert property (
    pos_zero |-> (s_reg.prior == $past(actual_pos)) && !homing_busy)
    else $error("saved position not taken at zeroing");

  chk_fine_speed_used: assert property (
    (s_reg.st == H_LEAVE || s_reg.st == H_BACK) |-> move_speed == s_reg.fine)
    else $error("fine phase not at fine speed");

  chk_home_ign_stops: assert property (
    (s_reg.st == H_SEEK && base == 6'h07) |-> move_dir_pos)
    else $error("mode 7 turned at an end switch");

  chk_fault_read_clr: assert property (
    clk_en && bus_req.rd && bus_req.addr == `AHL_OFF_FAULT &&
      !stall_event && !deviation_event |=> s_reg.faults == 2'h0)
    else $error("fault flags not cleared by read");

  chk_fault_sticky_set: assert property (
    clk_en && stall_event |=> s_reg.faults[0] [*1] ##1
      (s_reg.faults[0] || $past(clk_en && (bus_req.rd ||
       homing_search_command))))
    else $error("stall flag lost without a clear");

  chk_coil_select: assert property (
    clk_en |=> coil_state ==
      ($past(standby_zero) ? $past(s_reg.coil_opt) : 2'h0))
    else $error("coil state does not follow standstill option");

  chk_autoscale_wr: assert property (
    clk_en && bus_req.wr && bus_req.addr == `AHL_OFF_AUTOSCALE
      |=> amp_auto == $past(bus_req.wdata[0]))
    else $error("autoscale flag not written");

endmodule : ahl_axis

// ### dv/ahl_track.sv
// far side of one axis: stop switches, home switch, encoder levels
// assumes one step per mclk while move_active, jog only when idle
`timescale 1ns/1ps
module ahl_track
  import ahl_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        move_active,
  input  wire logic        move_dir_pos,
  input  wire logic        pos_zero,
  input  wire logic        enc_clear,
  input  wire logic        jog,
  input  wire logic        home_inv,
  input  wire ahl_enc_type enc_in,
  output ahl_sw_type       sw,
  output ahl_enc_type      enc,
  output logic [31:0]      actual_pos,
  output logic [31:0]      encoder_count
);
  // switch places are fixed on the track, counters are offsets
  int phys  = 0;
  int p_off = 0;
  int e_off = 0;
  always @(posedge mclk) begin
    if (jog)
      phys <= phys + 1;
    else if (move_active)
      phys <= move_dir_pos ? phys + 1 : phys - 1;
    if (pos_zero)
      p_off <= phys;
    if (enc_clear)
      e_off <= phys;
  end
  // one driver for the whole switch struct
  assign sw              = '{stop_left:  phys <= -20,
                             stop_right: phys >= 30,
                             home: (phys >= 5 && phys <= 8) ^ home_inv};
  assign enc             = enc_in;
  assign actual_pos      = 32'(phys - p_off);
  assign encoder_count   = 32'(phys - e_off);
endmodule : ahl_track

// ### dv/ahl_axis_test.sv
// bench for one axis: registers, homing searches, null latch, faults
// assumes ahl_track as switch and encoder side
`timescale 1ns/1ps
module ahl_axis_test
  import ahl_pkg::*;
;
  logic        mclk = 0, sys_rst = 1, clk_en = 1, cmd = 0;
  logic        stall = 0, dev = 0, sbz = 0, jog = 0, hinv = 0;
  logic [9:0]  load = 10'h000;
  ahl_bus_type bus = '0;
  ahl_enc_type enc_in = '0;
  ahl_sw_type  sw;
  ahl_enc_type enc;
  logic [31:0] rdata, apos, ecnt, speed, r, s;
  logic [15:0] fsteps;
  logic [1:0]  coil;
  logic        amp, busy, mov, dir, pz, ec;
  int          n_fail = 0, cmp_count = 0;
  always #25 mclk = ~mclk;
  ahl_axis uut (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en),
    .bus_req(bus), .bus_rdata(rdata), .homing_search_command(cmd),
    .sw(sw), .enc(enc), .actual_pos(apos), .encoder_count(ecnt),
    .load_value(load), .stall_event(stall), .deviation_event(dev),
    .standby_zero(sbz), .amp_auto(amp), .homing_busy(busy),
    .move_active(mov), .move_dir_pos(dir), .move_speed(speed),
    .pos_zero(pz), .enc_clear(ec), .coil_state(coil),
    .fullsteps_out(fsteps));
  ahl_track far (.mclk(mclk), .move_active(mov), .move_dir_pos(dir),
    .pos_zero(pz), .enc_clear(ec), .jog(jog), .home_inv(hinv),
    .enc_in(enc_in), .sw(sw), .enc(enc), .actual_pos(apos),
    .encoder_count(ecnt));
////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // latencies of the track are not fixed, so allow a small slack
  task automatic near(input logic [31:0] got, input logic [31:0] exp,
                      input logic [31:0] tol);
    cmp_count++;
    if ((got - exp + tol) <= 2 * tol) begin
    end else begin
      n_fail++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : near
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus.rd <= 1'b0;
    @(negedge mclk);
    d = rdata;
  endtask : rd
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a, r);
    chk(r, e);
  endtask : rchk
  task automatic go;
    @(posedge mclk);
    cmd <= 1'b1;
    @(posedge mclk);
    cmd <= 1'b0;
    @(negedge mclk);
  endtask : go
  task automatic pulse(input logic s_on, input logic d_on);
    @(posedge mclk);
    stall <= s_on;
    dev <= d_on;
    @(posedge mclk);
    stall <= 1'b0;
    dev <= 1'b0;
  endtask : pulse
////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rchk(8'hca, 32'h0000_00c8);
    rchk(8'hd0, 32'h0);
    wr(8'hca, 32'hffff_1234);
    rchk(8'hca, 32'h0000_1234);
    chk(fsteps, 32'h1234);
    // enable low must swallow a write
    @(posedge mclk);
    clk_en <= 1'b0;
    wr(8'hca, 32'h0000_0077);
    chk(fsteps, 32'h1234);
    clk_en <= 1'b1;
    wr(8'hc4, 32'h55);
    rchk(8'hc4, 32'h0);
    wr(8'hc0, 32'h1);
    rchk(8'hc0, 32'h1);
    chk(amp, 32'h1);
    @(posedge mclk);
    load <= 10'h3ff;
    rchk(8'hce, 32'h3ff);
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      sbz <= 1'b1;
      wr(8'hcc, 32'(i));
      repeat (2) @(negedge mclk);
      chk(coil, 32'(i));
    end
    @(posedge mclk);
    sbz <= 1'b0;
    repeat (2) @(negedge mclk);
    chk(coil, 32'h0);
    $display("register test done");
  endtask : t_regs
  task automatic t_faults;
    pulse(1'b1, 1'b0);
    rchk(8'hcf, 32'h1);
    rchk(8'hcf, 32'h0);
    pulse(1'b0, 1'b1);
    rchk(8'hcf, 32'h2);
    pulse(1'b1, 1'b1);
    rchk(8'hcf, 32'h3);
    pulse(1'b1, 1'b1);
    wr(8'hc1, 32'h0);
    go;
    chk(busy, 32'h0);
    rchk(8'hcf, 32'h0);
    $display("fault test done");
  endtask : t_faults
  task automatic t_home;
    byte unsigned md [13] = '{1, 2, 3, 4, 7, 65, 8, 1, 5, 65, 6, 1, 135};
    logic up;
    logic fine_seen;
    int k;
    wr(8'hc2, 32'h0000_0300);
    wr(8'hc3, 32'h0000_0040);
    foreach (md[i]) begin
      up = md[i] inside {2, 3, 6, 7, 65, 135};
      @(posedge mclk);
      hinv <= md[i][7];
      wr(8'hc1, {24'h0, md[i]});
      go;
      chk(busy, 32'h1);
      chk(speed, 32'h300);
      chk(dir, {31'h0, up});
      fine_seen = 1'b0;
      for (k = 0; k < 3000 && pz !== 1'b1; k++) begin
        @(negedge mclk);
        if (speed === 32'h40 && mov === 1'b1)
          fine_seen = 1'b1;
      end
      if (k == 3000) begin
        n_fail++;
        close_out;
      end
      s = apos;
      chk(fine_seen, 32'h1);
      rd(8'hc5, r);
      near(r, s, 32'd1);
      if (md[i] inside {2, 3}) begin
        rd(8'hc4, r);
        near(r, 32'd50, 32'd4);
      end
    end
    $display("homing test done");
  endtask : t_home
  task automatic nev(input logic [1:0] ab, input logic na, input logic hit);
    logic [31:0] oa, oe, ea, ee;
    rd(8'hc6, oa);
    rd(8'hc7, oe);
    @(posedge mclk);
    enc_in <= '{a: ab[0], b: ab[1], n: ~na};
    jog <= 1'b1;
    repeat (3) @(posedge mclk);
    jog <= 1'b0;
    @(posedge mclk);
    enc_in.n <= na;
    @(negedge mclk);
    ea = apos;
    ee = ecnt;
    repeat (3) @(posedge mclk);
    enc_in.n <= ~na;
    rchk(8'hc6, hit ? ea : oa);
    rchk(8'hc7, hit ? ee : oe);
  endtask : nev
  task automatic t_null;
    wr(8'hc9, 32'h010);
    nev(2'b00, 1'b0, 1'b1);
    wr(8'hc9, 32'h013);
    nev(2'b11, 1'b0, 1'b1);
    nev(2'b01, 1'b0, 1'b0);
    wr(8'hc9, 32'h01c);
    nev(2'b10, 1'b1, 1'b1);
    wr(8'hc9, 32'h000);
    nev(2'b00, 1'b0, 1'b0);
    wr(8'hc9, 32'h120);
    nev(2'b00, 1'b0, 1'b1);
    chk(ecnt, 32'h0);
    rchk(8'hc9, 32'h100);
    nev(2'b00, 1'b0, 1'b0);
    $display("null channel test done");
  endtask : t_null
  initial begin
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    rchk(8'hc1, 32'h1);
    t_regs;
    t_faults;
    t_home;
    t_null;
    close_out;
  end
endmodule : ahl_axis_test
